// ===== epfc_credit.sv
// module: burst credit counter shared by both ends.
// assumes ack and sent are one-cycle pulses from the owning end.
module epfc_credit (
    input wire logic clk,
    input wire logic srst,
    input wire logic ack,
    input wire logic [epfc_pkg::NUMP_W-1:0] nump,
    input wire logic sent,
    output logic [epfc_pkg::NUMP_W-1:0] credit
);
    logic [epfc_pkg::NUMP_W-1:0] lim_q;
    logic [epfc_pkg::NUMP_W-1:0] out_q;
    logic [epfc_pkg::NUMP_W-1:0] lim_d;

    always_comb begin
        lim_d = (nump < epfc_pkg::MAX_BURST) ? nump : epfc_pkg::MAX_BURST;
    end

    // --------------------------------
    // limit and outstanding count
    // --------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            lim_q <= epfc_pkg::NUMP_ZERO;
        end else if (ack) begin
            lim_q <= lim_d;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            out_q <= epfc_pkg::NUMP_ZERO;
        end else if (ack) begin
            out_q <= sent ? 5'h01 : epfc_pkg::NUMP_ZERO;
        end else if (sent) begin
            out_q <= out_q + 5'h01;
        end
    end

    assign credit = (lim_q > out_q) ? lim_q - out_q : epfc_pkg::NUMP_ZERO;
endmodule // epfc_credit

// ===== epfc_dev.sv
// module: device endpoint end, one endpoint with flow control, burst and responses.
// assumes host end keeps its own rules; user side supplies readiness and data lengths.
module epfc_dev (
    input wire logic CLK,
    input wire logic SRST,
    epfc_if.dev LINK,
    input wire epfc_pkg::xfer_t XFER,
    input wire logic DIR_IN,
    input wire logic STREAMS,
    input wire logic HALT,
    input wire logic TX_READY,
    input wire logic RX_READY,
    input wire logic [epfc_pkg::LEN_W-1:0] TX_LEN,
    input wire logic SET_ADDR,
    input wire logic [epfc_pkg::ADDR_W-1:0] NEW_ADDR,
    input wire logic STREAM_ERDY,
    output logic FLOW,
    output logic XFER_DONE,
    output logic [epfc_pkg::ADDR_W-1:0] ADDR,
    output logic RX_VLD,
    output logic [epfc_pkg::LEN_W-1:0] RX_LEN
);
    logic [epfc_pkg::ADDR_W-1:0] addr_q;
    logic [epfc_pkg::SEQ_W-1:0] seq_q;
    logic flow_q;
    logic wait_ack_q;
    logic pend_erdy_q;
    logic sending_q;
    logic done_q;
    logic [epfc_pkg::NUMP_W-1:0] credit;
    logic [epfc_pkg::NUMP_W-1:0] last_nump_q;
    logic tp_ok;
    logic tp_ack;
    logic dp_ok;
    logic isoch;
    logic send_dp;
    logic dp_short;
    logic dp_last;
    logic erdy_now;
    logic [epfc_pkg::NUMP_W-1:0] out_nump;

    assign isoch = (XFER == epfc_pkg::XFER_ISOCH);

    // --------------------------------
    // validity checks
    // --------------------------------
    always_comb begin
        tp_ok = LINK.h_tp_vld && LINK.h_tp_addr == addr_q && LINK.h_tp_ep < epfc_pkg::EP_CONFIGURED
            && LINK.h_tp_dir_in == DIR_IN && LINK.h_tp_seq == seq_q
            && LINK.h_tp_type == epfc_pkg::TP_ACK;
        tp_ack = tp_ok && DIR_IN && !isoch;
        dp_ok = LINK.h_dp_vld && !DIR_IN && !isoch && LINK.h_dp_seq == seq_q;
    end

    // --------------------------------
    // device address
    // --------------------------------
    always_ff @(posedge CLK) begin
        if (SRST) begin
            addr_q <= epfc_pkg::ADDR_RESET;
        end else if (SET_ADDR && NEW_ADDR >= epfc_pkg::ADDR_MIN
            && NEW_ADDR <= epfc_pkg::ADDR_MAX) begin
            addr_q <= NEW_ADDR;
        end
    end

    // --------------------------------
    // in data transmit and credit
    // --------------------------------
    epfc_credit u_credit (
        .clk(CLK),
        .srst(SRST),
        .ack(tp_ack),
        .nump(LINK.h_tp_nump),
        .sent(send_dp),
        .credit(credit)
    );

    assign dp_short = TX_LEN < epfc_pkg::MAX_PKT;
    assign dp_last = dp_short || credit == 5'h01;
    assign send_dp = sending_q && TX_READY && !HALT && credit != epfc_pkg::NUMP_ZERO
        && !done_q;

    always_ff @(posedge CLK) begin
        if (SRST) begin
            sending_q <= 1'b0;
        end else if (tp_ack && !LINK.h_tp_deferred && !HALT && TX_READY
            && LINK.h_tp_nump != epfc_pkg::NUMP_ZERO) begin
            sending_q <= 1'b1;
        end else if (send_dp && dp_last) begin
            sending_q <= 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            done_q <= 1'b0;
        end else if (send_dp && dp_short) begin
            done_q <= 1'b1;
        end else if (tp_ack && LINK.h_tp_nump != epfc_pkg::NUMP_ZERO) begin
            done_q <= 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            seq_q <= epfc_pkg::SEQ_RESET;
        end else if (send_dp || (dp_ok && RX_READY)) begin
            seq_q <= seq_q + 5'h01;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            wait_ack_q <= 1'b0;
        end else if (send_dp) begin
            wait_ack_q <= 1'b1;
        end else if (tp_ack) begin
            wait_ack_q <= 1'b0;
        end
    end

    // --------------------------------
    // out data receive
    // --------------------------------
    always_comb begin
        out_nump = epfc_pkg::NUMP_ZERO;
        if (RX_READY && last_nump_q != epfc_pkg::NUMP_ZERO) begin
            out_nump = last_nump_q - 5'h01;
        end
        if (RX_READY && out_nump == epfc_pkg::NUMP_ZERO && LINK.h_dp_len == epfc_pkg::MAX_PKT) begin
            out_nump = 5'h01;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            last_nump_q <= epfc_pkg::MAX_BURST;
        end else if (dp_ok) begin
            last_nump_q <= (LINK.h_dp_len < epfc_pkg::MAX_PKT) ? epfc_pkg::MAX_BURST : out_nump;
        end
    end

    // --------------------------------
    // flow control state
    // --------------------------------
    always_comb begin
        erdy_now = 1'b0;
        if (tp_ok && !isoch && LINK.h_tp_deferred) begin
            erdy_now = HALT || (DIR_IN ? TX_READY : RX_READY);
        end else if ((flow_q || pend_erdy_q) && !isoch && !wait_ack_q
            && (pend_erdy_q || !LINK.h_tp_vld)) begin
            erdy_now = (DIR_IN ? TX_READY : RX_READY) && !HALT;
        end else if (!flow_q && STREAMS && STREAM_ERDY && XFER == epfc_pkg::XFER_BULK) begin
            erdy_now = 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            pend_erdy_q <= 1'b0;
        end else if (erdy_now) begin
            pend_erdy_q <= 1'b0;
        end else if (tp_ok && LINK.h_tp_deferred && !isoch) begin
            pend_erdy_q <= 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            flow_q <= 1'b0;
        end else if (isoch) begin
            flow_q <= 1'b0;
        end else if ((tp_ack && !LINK.h_tp_deferred && !HALT && !TX_READY)
            || (send_dp && dp_last && !dp_short) || (dp_ok && out_nump == epfc_pkg::NUMP_ZERO)
            || (dp_ok && !RX_READY)) begin
            flow_q <= 1'b1;
        end else if (erdy_now || dp_ok || (tp_ok && !LINK.h_tp_deferred
            && LINK.h_tp_nump != epfc_pkg::NUMP_ZERO)) begin
            flow_q <= 1'b0;
        end
    end

    // --------------------------------
    // link outputs
    // --------------------------------
    always_ff @(posedge CLK) begin
        if (SRST) begin
            LINK.d_tp_vld <= 1'b0;
            LINK.d_tp_type <= epfc_pkg::TP_NONE;
            LINK.d_tp_seq <= epfc_pkg::SEQ_RESET;
            LINK.d_tp_nump <= epfc_pkg::NUMP_ZERO;
        end else begin
            LINK.d_tp_vld <= 1'b0;
            LINK.d_tp_type <= epfc_pkg::TP_NONE;
            LINK.d_tp_seq <= seq_q;
            LINK.d_tp_nump <= epfc_pkg::NUMP_ZERO;
            if (erdy_now) begin
                LINK.d_tp_vld <= 1'b1;
                LINK.d_tp_type <= epfc_pkg::TP_ERDY;
            end else if ((tp_ack && !LINK.h_tp_deferred && HALT) || (dp_ok && HALT)) begin
                LINK.d_tp_vld <= 1'b1;
                LINK.d_tp_type <= epfc_pkg::TP_STALL;
            end else if ((tp_ack && !LINK.h_tp_deferred && !TX_READY) || (dp_ok && !RX_READY)) begin
                LINK.d_tp_vld <= 1'b1;
                LINK.d_tp_type <= epfc_pkg::TP_NRDY;
            end else if (dp_ok) begin
                LINK.d_tp_vld <= 1'b1;
                LINK.d_tp_type <= epfc_pkg::TP_ACK;
                LINK.d_tp_seq <= seq_q + 5'h01;
                LINK.d_tp_nump <= out_nump;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            LINK.d_dp_vld <= 1'b0;
            LINK.d_dp_seq <= epfc_pkg::SEQ_RESET;
            LINK.d_dp_len <= '0;
            LINK.d_dp_eob <= 1'b0;
        end else begin
            LINK.d_dp_vld <= send_dp;
            LINK.d_dp_seq <= seq_q;
            LINK.d_dp_len <= TX_LEN;
            LINK.d_dp_eob <= send_dp && dp_last && !dp_short;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            RX_VLD <= 1'b0;
            RX_LEN <= '0;
            XFER_DONE <= 1'b0;
        end else begin
            RX_VLD <= dp_ok && RX_READY && !HALT;
            RX_LEN <= LINK.h_dp_len;
            XFER_DONE <= (dp_ok && RX_READY && LINK.h_dp_len < epfc_pkg::MAX_PKT)
                || (send_dp && dp_short);
        end
    end

    assign FLOW = flow_q;
    assign ADDR = addr_q;
endmodule // epfc_dev

// ===== epfc_host.sv
// module: host end, issues requests and data and acks device data.
// assumes the device end keeps its own rules; user side gives commands.
module epfc_host (
    input wire logic CLK,
    input wire logic SRST,
    epfc_if.host LINK,
    input wire logic [epfc_pkg::ADDR_W-1:0] DEV_ADDR,
    input wire logic IN_REQ,
    input wire logic DEFERRED,
    input wire logic [epfc_pkg::NUMP_W-1:0] WANT_NUMP,
    input wire logic MORE_XFER,
    input wire logic OUT_SEND,
    input wire logic [epfc_pkg::LEN_W-1:0] OUT_LEN,
    output logic OUT_READY,
    output logic IN_DONE,
    output logic [epfc_pkg::SEQ_W-1:0] IN_SEQ,
    output logic [epfc_pkg::NUMP_W-1:0] OUT_CREDIT
);
    logic [epfc_pkg::SEQ_W-1:0] in_seq_q;
    logic [epfc_pkg::SEQ_W-1:0] out_seq_q;
    logic [epfc_pkg::NUMP_W-1:0] nump_q;
    logic [epfc_pkg::NUMP_W-1:0] ack_nump;
    logic [epfc_pkg::NUMP_W-1:0] want;
    logic dp_full;
    logic dev_ack;
    logic out_go;
    logic primed_q;

    assign want = (WANT_NUMP > epfc_pkg::MAX_BURST) ? epfc_pkg::MAX_BURST : WANT_NUMP;
    assign dp_full = LINK.d_dp_len == epfc_pkg::MAX_PKT;
    assign dev_ack = LINK.d_tp_vld && LINK.d_tp_type == epfc_pkg::TP_ACK;

    // --------------------------------
    // ack numP for in data
    // --------------------------------
    always_comb begin
        ack_nump = want;
        if (nump_q != epfc_pkg::NUMP_ZERO && want < nump_q - 5'h01) begin
            ack_nump = nump_q - 5'h01;
        end
        if (LINK.d_dp_eob || (!dp_full && !MORE_XFER)) begin
            ack_nump = epfc_pkg::NUMP_ZERO;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            nump_q <= epfc_pkg::NUMP_ZERO;
            in_seq_q <= epfc_pkg::SEQ_RESET;
        end else if (LINK.d_dp_vld) begin
            nump_q <= ack_nump;
            in_seq_q <= LINK.d_dp_seq + 5'h01;
        end else if (IN_REQ) begin
            nump_q <= want;
        end
    end

    // --------------------------------
    // out burst credit
    // --------------------------------
    // first cycle after reset loads a full burst of out credit
    always_ff @(posedge CLK) begin
        if (SRST) begin
            primed_q <= 1'b0;
        end else begin
            primed_q <= 1'b1;
        end
    end

    epfc_credit u_credit (
        .clk(CLK),
        .srst(SRST),
        .ack(dev_ack || !primed_q),
        .nump(primed_q ? LINK.d_tp_nump : epfc_pkg::MAX_BURST),
        .sent(out_go),
        .credit(OUT_CREDIT)
    );

    assign OUT_READY = OUT_CREDIT != epfc_pkg::NUMP_ZERO;
    assign out_go = OUT_SEND && OUT_READY;

    always_ff @(posedge CLK) begin
        if (SRST) begin
            out_seq_q <= epfc_pkg::SEQ_RESET;
        end else if (out_go) begin
            out_seq_q <= out_seq_q + 5'h01;
        end
    end

    // --------------------------------
    // link outputs
    // --------------------------------
    always_ff @(posedge CLK) begin
        if (SRST) begin
            LINK.h_tp_vld <= 1'b0;
            LINK.h_tp_type <= epfc_pkg::TP_NONE;
            LINK.h_tp_deferred <= 1'b0;
            LINK.h_tp_dir_in <= 1'b0;
            LINK.h_tp_addr <= epfc_pkg::ADDR_RESET;
            LINK.h_tp_ep <= '0;
            LINK.h_tp_seq <= epfc_pkg::SEQ_RESET;
            LINK.h_tp_nump <= epfc_pkg::NUMP_ZERO;
            LINK.h_tp_pp <= 1'b0;
        end else begin
            LINK.h_tp_vld <= LINK.d_dp_vld || IN_REQ;
            LINK.h_tp_type <= epfc_pkg::TP_ACK;
            LINK.h_tp_deferred <= !LINK.d_dp_vld && DEFERRED;
            LINK.h_tp_dir_in <= 1'b1;
            LINK.h_tp_addr <= DEV_ADDR;
            LINK.h_tp_ep <= '0;
            LINK.h_tp_seq <= LINK.d_dp_vld ? LINK.d_dp_seq + 5'h01 : in_seq_q;
            LINK.h_tp_nump <= LINK.d_dp_vld ? ack_nump : want;
            LINK.h_tp_pp <= MORE_XFER;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            LINK.h_dp_vld <= 1'b0;
            LINK.h_dp_seq <= epfc_pkg::SEQ_RESET;
            LINK.h_dp_len <= '0;
            IN_DONE <= 1'b0;
        end else begin
            LINK.h_dp_vld <= out_go;
            LINK.h_dp_seq <= out_seq_q;
            LINK.h_dp_len <= OUT_LEN;
            IN_DONE <= LINK.d_dp_vld && (!dp_full || LINK.d_dp_eob);
        end
    end

    assign IN_SEQ = in_seq_q;
endmodule // epfc_host

// ===== epfc_if.sv
// interface: the link between host end and device endpoint end.
// assumes both ends clocked by the same CLK; one packet per strobe.
interface epfc_if;
    // host to device transaction packet
    logic h_tp_vld;
    epfc_pkg::tp_t h_tp_type;
    logic h_tp_deferred;
    logic h_tp_dir_in;
    logic [epfc_pkg::ADDR_W-1:0] h_tp_addr;
    logic [epfc_pkg::EPN_W-1:0] h_tp_ep;
    logic [epfc_pkg::SEQ_W-1:0] h_tp_seq;
    logic [epfc_pkg::NUMP_W-1:0] h_tp_nump;
    logic h_tp_pp;
    // host to device data packet
    logic h_dp_vld;
    logic [epfc_pkg::SEQ_W-1:0] h_dp_seq;
    logic [epfc_pkg::LEN_W-1:0] h_dp_len;
    // device to host transaction packet
    logic d_tp_vld;
    epfc_pkg::tp_t d_tp_type;
    logic [epfc_pkg::SEQ_W-1:0] d_tp_seq;
    logic [epfc_pkg::NUMP_W-1:0] d_tp_nump;
    // device to host data packet
    logic d_dp_vld;
    logic [epfc_pkg::SEQ_W-1:0] d_dp_seq;
    logic [epfc_pkg::LEN_W-1:0] d_dp_len;
    logic d_dp_eob;

    modport host (
        output h_tp_vld, h_tp_type, h_tp_deferred, h_tp_dir_in, h_tp_addr, h_tp_ep,
        output h_tp_seq, h_tp_nump, h_tp_pp, h_dp_vld, h_dp_seq, h_dp_len,
        input d_tp_vld, d_tp_type, d_tp_seq, d_tp_nump, d_dp_vld, d_dp_seq, d_dp_len,
        input d_dp_eob
    );
    modport dev (
        input h_tp_vld, h_tp_type, h_tp_deferred, h_tp_dir_in, h_tp_addr, h_tp_ep,
        input h_tp_seq, h_tp_nump, h_tp_pp, h_dp_vld, h_dp_seq, h_dp_len,
        output d_tp_vld, d_tp_type, d_tp_seq, d_tp_nump, d_dp_vld, d_dp_seq, d_dp_len,
        output d_dp_eob
    );
endinterface

// ===== epfc_pkg.sv
// package: packet codes, field widths and constants shared by the endpoint and the host end.
// assumes one clock CLK at 20 MHz and a synchronous active-high reset SRST.
package epfc_pkg;
    localparam int NUMP_W = 5;
    localparam int SEQ_W = 5;
    localparam int LEN_W = 11;
    localparam int ADDR_W = 7;
    localparam int EPN_W = 4;
    localparam logic [NUMP_W-1:0] MAX_BURST = 5'h10;
    localparam logic [LEN_W-1:0] MAX_PKT = 11'h400;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 7'h00;
    localparam logic [ADDR_W-1:0] ADDR_MIN = 7'h01;
    localparam logic [ADDR_W-1:0] ADDR_MAX = 7'h7f;
    localparam logic [SEQ_W-1:0] SEQ_RESET = 5'h00;
    localparam logic [NUMP_W-1:0] NUMP_ZERO = 5'h00;
    localparam logic [3:0] EP_CONFIGURED = 4'h1;

    typedef enum logic [1:0] {
        XFER_BULK,
        XFER_CONTROL,
        XFER_INTERRUPT,
        XFER_ISOCH
    } xfer_t;

    typedef enum logic [2:0] {
        TP_NONE,
        TP_ACK,
        TP_NRDY,
        TP_ERDY,
        TP_STALL
    } tp_t;
endpackage

// ===== epfc_props.sv
// checker: link properties between host end and device endpoint end.
// assumes one clock CLK and synchronous active-high SRST for both ends.
module epfc_props (
    input wire logic CLK,
    input wire logic SRST,
    input wire logic h_tp_vld,
    input wire epfc_pkg::tp_t h_tp_type,
    input wire logic [epfc_pkg::NUMP_W-1:0] h_tp_nump,
    input wire logic h_dp_vld,
    input wire logic d_tp_vld,
    input wire epfc_pkg::tp_t d_tp_type,
    input wire logic [epfc_pkg::NUMP_W-1:0] d_tp_nump,
    input wire logic d_dp_vld,
    input wire logic [epfc_pkg::SEQ_W-1:0] d_dp_seq,
    input wire logic [epfc_pkg::LEN_W-1:0] d_dp_len,
    input wire logic d_dp_eob
);
    // ----------------------------------------
    // clocking
    // ----------------------------------------
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (SRST);

    // ----------------------------------------
    // properties
    // ----------------------------------------
    AST_HOST_NUMP_CAP: assert property (
        h_tp_vld && h_tp_type == epfc_pkg::TP_ACK |-> h_tp_nump <= epfc_pkg::MAX_BURST)
        else $error("host numP above max burst");
    AST_DEV_NUMP_CAP: assert property (
        d_tp_vld && d_tp_type == epfc_pkg::TP_ACK |-> d_tp_nump <= epfc_pkg::MAX_BURST)
        else $error("device numP above max burst");
    AST_SHORT_ENDS: assert property (
        d_dp_vld && d_dp_len < epfc_pkg::MAX_PKT |=> !d_dp_vld)
        else $error("data sent after short packet");
    AST_EOB_FULL: assert property (
        d_dp_vld && d_dp_eob |-> d_dp_len == epfc_pkg::MAX_PKT ##1 !d_dp_vld)
        else $error("end of burst packet not full or not last");
    AST_EOB_ZERO_ACK: assert property (
        d_dp_vld && d_dp_eob |=> h_tp_vld && h_tp_type == epfc_pkg::TP_ACK
        && h_tp_nump == epfc_pkg::NUMP_ZERO)
        else $error("end of burst not acked with zero");
    AST_NO_ERDY_OUTSTANDING: assert property (
        d_dp_vld |=> !(d_tp_vld && d_tp_type == epfc_pkg::TP_ERDY))
        else $error("erdy before data acked");
    AST_ACK_FROM_DP: assert property (
        d_tp_vld && d_tp_type == epfc_pkg::TP_ACK |-> $past(h_dp_vld))
        else $error("device ack without data packet");
    AST_SEQ_STEP: assert property (
        d_dp_vld && $past(d_dp_vld) |-> d_dp_seq == $past(d_dp_seq) + 5'h01)
        else $error("data sequence did not step");
endmodule // epfc_props

// ===== tb_top.sv
// testbench: host end and device end joined by the link, with scoreboard.
// assumes package, interface, design modules and checker compiled first.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic CLK, SRST, DIR_IN, STREAMS, HALT, TX_READY, RX_READY, SET_ADDR, STREAM_ERDY;
    logic IN_REQ, DEFERRED, OUT_SEND, FLOW, XFER_DONE, RX_VLD, OUT_READY, IN_DONE;
    epfc_pkg::xfer_t XFER;
    logic [epfc_pkg::LEN_W-1:0] TX_LEN, OUT_LEN, RX_LEN;
    logic [epfc_pkg::ADDR_W-1:0] NEW_ADDR, ADDR, DEV_ADDR;
    logic [epfc_pkg::NUMP_W-1:0] WANT_NUMP, OUT_CREDIT;
    logic [epfc_pkg::SEQ_W-1:0] IN_SEQ;
    logic [7:0] note_q[$];
    logic [7:0] seen, want;
    int fails = 0, check_count = 0, dps = 0, eobs = 0, dones = 0, cycles = 0;

    // ----------------------------------------
    // structure
    // ----------------------------------------
    epfc_if lk();
    epfc_dev epfc_dev_inst (.CLK(CLK), .SRST(SRST), .LINK(lk), .XFER(XFER), .DIR_IN(DIR_IN),
        .STREAMS(STREAMS), .HALT(HALT), .TX_READY(TX_READY), .RX_READY(RX_READY),
        .TX_LEN(TX_LEN), .SET_ADDR(SET_ADDR), .NEW_ADDR(NEW_ADDR), .STREAM_ERDY(STREAM_ERDY),
        .FLOW(FLOW), .XFER_DONE(XFER_DONE), .ADDR(ADDR), .RX_VLD(RX_VLD), .RX_LEN(RX_LEN));
    epfc_host epfc_host_inst (.CLK(CLK), .SRST(SRST), .LINK(lk), .DEV_ADDR(DEV_ADDR),
        .IN_REQ(IN_REQ), .DEFERRED(DEFERRED), .WANT_NUMP(WANT_NUMP), .MORE_XFER(1'b0),
        .OUT_SEND(OUT_SEND), .OUT_LEN(OUT_LEN), .OUT_READY(OUT_READY), .IN_DONE(IN_DONE),
        .IN_SEQ(IN_SEQ), .OUT_CREDIT(OUT_CREDIT));
    epfc_props epfc_props_inst (.CLK(CLK), .SRST(SRST), .h_tp_vld(lk.h_tp_vld),
        .h_tp_type(lk.h_tp_type), .h_tp_nump(lk.h_tp_nump), .h_dp_vld(lk.h_dp_vld),
        .d_tp_vld(lk.d_tp_vld), .d_tp_type(lk.d_tp_type), .d_tp_nump(lk.d_tp_nump),
        .d_dp_vld(lk.d_dp_vld), .d_dp_seq(lk.d_dp_seq), .d_dp_len(lk.d_dp_len),
        .d_dp_eob(lk.d_dp_eob));

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge CLK);
        #2;
    endtask
    task automatic note(input epfc_pkg::tp_t t, input logic [4:0] n);
        note_q.push_back({t, n});
    endtask
    task automatic req(input logic dfr);
        DEFERRED = dfr;
        IN_REQ = 1'b1;
        step(1);
        IN_REQ = 1'b0;
        step(6);
    endtask
    task automatic send_out(input logic [10:0] len);
        OUT_LEN = len;
        OUT_SEND = 1'b1;
        step(1);
        OUT_SEND = 1'b0;
        step(6);
    endtask
    task automatic do_reset();
        SRST = 1'b1;
        step(2);
        SRST = 1'b0;
        step(2);
    endtask
    task automatic end_test(input string name);
        check(note_q.size(), 0);
        $display("test done: %s", name);
    endtask

    // ----------------------------------------
    // clock, timeout and scoreboard
    // ----------------------------------------
    initial begin
        CLK = 1'b0;
        forever #25 CLK = ~CLK;
    end
    always @(posedge CLK) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            print_verdict();
        end
    end
    always @(negedge CLK) begin
        if (lk.d_tp_vld === 1'b1) begin
            seen = {lk.d_tp_type, (lk.d_tp_type == epfc_pkg::TP_ACK) ? lk.d_tp_nump : 5'h00};
            want = (note_q.size() > 0) ? note_q.pop_front() : 8'hff;
            check(seen, want);
        end
        dps += (lk.d_dp_vld === 1'b1);
        eobs += (lk.d_dp_vld === 1'b1 && lk.d_dp_eob === 1'b1);
        dones += (XFER_DONE === 1'b1);
    end

    // ----------------------------------------
    // stimulus
    // ----------------------------------------
    initial begin
        {SRST, DIR_IN, HALT, SET_ADDR, STREAM_ERDY, IN_REQ, DEFERRED, OUT_SEND} = 8'h80;
        {STREAMS, TX_READY, RX_READY} = 3'h0;
        XFER = epfc_pkg::XFER_BULK;
        TX_LEN = epfc_pkg::MAX_PKT;
        OUT_LEN = epfc_pkg::MAX_PKT;
        NEW_ADDR = 7'h00;
        DEV_ADDR = 7'h00;
        WANT_NUMP = 5'h01;
        void'($urandom(51997));
        step(8);
        SRST = 1'b0;
        step(1);
        check(ADDR, epfc_pkg::ADDR_RESET);
        check(FLOW, 1'b0);
        SET_ADDR = 1'b1;
        step(1);
        SET_ADDR = 1'b0;
        step(1);
        check(ADDR, epfc_pkg::ADDR_RESET);
        NEW_ADDR = 7'($urandom_range(1, 127));
        SET_ADDR = 1'b1;
        step(1);
        SET_ADDR = 1'b0;
        step(1);
        check(ADDR, NEW_ADDR);
        DEV_ADDR = NEW_ADDR;
        end_test("address");
        DIR_IN = 1'b1;
        HALT = 1'b1;
        note(epfc_pkg::TP_STALL, 5'h00);
        req(1'b0);
        HALT = 1'b0;
        note(epfc_pkg::TP_NRDY, 5'h00);
        req(1'b0);
        check(FLOW, 1'b1);
        HALT = 1'b1;
        note(epfc_pkg::TP_ERDY, 5'h00);
        req(1'b1);
        check(FLOW, 1'b0);
        HALT = 1'b0;
        req(1'b1);
        note(epfc_pkg::TP_ERDY, 5'h00);
        TX_READY = 1'b1;
        step(6);
        DEV_ADDR = ~NEW_ADDR;
        req(1'b0);
        DEV_ADDR = NEW_ADDR;
        end_test("in responses");
        dps = 0;
        note(epfc_pkg::TP_ERDY, 5'h00);
        req(1'b0);
        check(dps, 1);
        check(eobs, 1);
        check(FLOW, 1'b0);
        TX_LEN = 11'($urandom_range(1, 1023));
        WANT_NUMP = 5'h04;
        dps = 0;
        req(1'b0);
        check(dps, 1);
        check(dones, 1);
        end_test("in burst");
        do_reset();
        check(FLOW, 1'b0);
        DIR_IN = 1'b0;
        RX_READY = 1'b1;
        note(epfc_pkg::TP_ACK, 5'h0f);
        send_out(epfc_pkg::MAX_PKT);
        check(OUT_CREDIT, 5'h0f);
        OUT_LEN = 11'($urandom_range(1, 1023));
        note(epfc_pkg::TP_ACK, 5'h0e);
        send_out(OUT_LEN);
        check(RX_LEN, OUT_LEN);
        check(dones, 2);
        RX_READY = 1'b0;
        note(epfc_pkg::TP_NRDY, 5'h00);
        send_out(epfc_pkg::MAX_PKT);
        check(FLOW, 1'b1);
        note(epfc_pkg::TP_ERDY, 5'h00);
        RX_READY = 1'b1;
        step(6);
        check(FLOW, 1'b0);
        end_test("out");
        do_reset();
        DEV_ADDR = epfc_pkg::ADDR_RESET;
        XFER = epfc_pkg::XFER_ISOCH;
        DIR_IN = 1'b1;
        HALT = 1'b1;
        req(1'b0);
        req(1'b1);
        check(FLOW, 1'b0);
        XFER = epfc_pkg::XFER_BULK;
        HALT = 1'b0;
        end_test("isochronous");
        STREAMS = 1'b1;
        note(epfc_pkg::TP_ERDY, 5'h00);
        repeat (2) begin
            STREAM_ERDY = 1'b1;
            step(1);
            STREAM_ERDY = 1'b0;
            step(6);
            STREAMS = 1'b0;
        end
        end_test("streams");
        print_verdict();
    end
endmodule // tb_top
